// ===== fpcsr_pkg.sv
// Constants for the floating-point control and status register bank.
// Assumes a 12-bit CSR address space with 32-bit data.
package fpcsr_pkg;

  // ==========================================================================
  // Addresses
  localparam logic [11:0] FPCSR_ADDR_FLAGS  = 12'h001;
  localparam logic [11:0] FPCSR_ADDR_ROUND  = 12'h002;
  localparam logic [11:0] FPCSR_ADDR_CTRL   = 12'h003;

  // ==========================================================================
  // Field layout and reset values
  localparam int          FPCSR_FLAGS_W     = 5;
  localparam int          FPCSR_ROUND_W     = 3;
  localparam int          FPCSR_CTRL_RM_LSB = 5;
  localparam int          FPCSR_CTRL_RM_MSB = 7;
  localparam int          FPCSR_FLAG_INVALID  = 4;
  localparam int          FPCSR_FLAG_DIVZERO  = 3;
  localparam int          FPCSR_FLAG_OVERFLOW = 2;
  localparam int          FPCSR_FLAG_UNDERFL  = 1;
  localparam int          FPCSR_FLAG_INEXACT  = 0;
  localparam logic [4:0]  FPCSR_FLAGS_RST   = 5'h00;
  localparam logic [2:0]  FPCSR_ROUND_RST   = 3'h0;

  // ==========================================================================
  // Access operations
  typedef enum logic [1:0] {
    FPCSR_OP_READ  = 2'h0,
    FPCSR_OP_WRITE = 2'h1,
    FPCSR_OP_SET   = 2'h3,
    FPCSR_OP_CLEAR = 2'h2
  } fpcsr_op_t;

  // ==========================================================================
  // Rounding codes
  typedef enum logic [2:0] {
    FPCSR_RM_NEAREST_EVEN   = 3'h0,
    FPCSR_RM_TOWARD_ZERO    = 3'h1,
    FPCSR_RM_DOWNWARD       = 3'h2,
    FPCSR_RM_UPWARD         = 3'h3,
    FPCSR_RM_NEAREST_MAXMAG = 3'h4,
    FPCSR_RM_RESV5          = 3'h5,
    FPCSR_RM_RESV6          = 3'h6,
    FPCSR_RM_DYNAMIC        = 3'h7
  } fpcsr_rm_t;

endpackage : fpcsr_pkg

// ===== fpcsr_bank.sv
// Floating-point control/status register bank: rounding mode and sticky flags.
// Assumes CSR decode and the floating-point unit share clk; all inputs are
// same-domain logic, so none is synchronised.
`timescale 1ns/1ps

module fpcsr_bank (
  input  wire logic                 clk,
  input  wire logic                 rst,
  input  wire logic                 ce,
  // CSR access port
  input  wire logic                 csr_valid,
  input  wire logic [11:0]          csr_addr,
  input  wire fpcsr_pkg::fpcsr_op_t csr_op,
  input  wire logic [31:0]          csr_wdata,
  output logic [31:0]               csr_rdata,
  output logic                      csr_hit,
  // Floating-point unit side
  input  wire logic                 fpu_flags_valid,
  input  wire logic [4:0]           fpu_flags,
  input  wire logic [2:0]           instr_round_field,
  output logic [2:0]                fpu_round_mode,
  output logic                      fpu_round_illegal,
  output logic [2:0]                dyn_round_mode,
  output logic                      invalid_op_flag,
  output logic                      div_by_zero_flag,
  output logic                      overflow_flag,
  output logic                      underflow_flag,
  output logic                      inexact_flag
);
  import fpcsr_pkg::*;

  // ==========================================================================
  // Storage; each field appears in the control view and in its own view
  logic [FPCSR_FLAGS_W-1:0] flags;
  logic [FPCSR_ROUND_W-1:0] round_sel;

  logic                     hit_flags;
  logic                     hit_round;
  logic                     hit_ctrl;
  logic [31:0]              cur_view;
  logic [31:0]              new_view;
  logic                     do_write;
  logic [FPCSR_FLAGS_W-1:0] next_flags;
  logic [FPCSR_ROUND_W-1:0] next_round_sel;

  assign hit_flags = csr_valid && (csr_addr == FPCSR_ADDR_FLAGS);
  assign hit_round = csr_valid && (csr_addr == FPCSR_ADDR_ROUND);
  assign hit_ctrl  = csr_valid && (csr_addr == FPCSR_ADDR_CTRL);
  assign csr_hit   = hit_flags || hit_round || hit_ctrl;

  // ==========================================================================
  // Current value as seen through the addressed view
  always_comb begin
    cur_view = 32'h0000_0000;
    if (hit_flags) begin
      cur_view[FPCSR_FLAGS_W-1:0] = flags;
    end else if (hit_round) begin
      cur_view[FPCSR_ROUND_W-1:0] = round_sel;
    end else if (hit_ctrl) begin
      cur_view[FPCSR_CTRL_RM_MSB:FPCSR_CTRL_RM_LSB] = round_sel;
      cur_view[FPCSR_FLAGS_W-1:0] = flags;
    end
  end

  // ==========================================================================
  // Value written back; a read leaves every field alone
  always_comb begin
    new_view = cur_view;
    do_write = 1'b0;
    case (csr_op)
      FPCSR_OP_READ: begin
        new_view = cur_view;
        do_write = 1'b0;
      end
      FPCSR_OP_WRITE: begin
        new_view = csr_wdata;
        do_write = 1'b1;
      end
      FPCSR_OP_SET: begin
        new_view = cur_view | csr_wdata;
        do_write = (csr_wdata != 32'h0000_0000);
      end
      FPCSR_OP_CLEAR: begin
        new_view = cur_view & ~csr_wdata;
        do_write = (csr_wdata != 32'h0000_0000);
      end
      default: begin
        new_view = cur_view;
        do_write = 1'b0;
      end
    endcase
  end

  // ==========================================================================
  // Next storage values; reserved bits of the source are dropped
  always_comb begin
    next_flags     = flags;
    next_round_sel = round_sel;
    if (do_write && hit_flags) begin
      next_flags = new_view[FPCSR_FLAGS_W-1:0];
    end
    if (do_write && hit_round) begin
      next_round_sel = new_view[FPCSR_ROUND_W-1:0];
    end
    if (do_write && hit_ctrl) begin
      next_flags     = new_view[FPCSR_FLAGS_W-1:0];
      next_round_sel = new_view[FPCSR_CTRL_RM_MSB:FPCSR_CTRL_RM_LSB];
    end
    // FPU event wins over a simultaneous software clear
    if (fpu_flags_valid) begin
      next_flags = next_flags | fpu_flags;
    end
  end

  // ==========================================================================
  // Flag storage
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      flags <= FPCSR_FLAGS_RST;
    end else if (ce) begin
      flags <= next_flags;
    end
  end

  // ==========================================================================
  // Rounding storage; any 3-bit value is kept, even reserved codes
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      round_sel <= FPCSR_ROUND_RST;
    end else if (ce) begin
      round_sel <= next_round_sel;
    end
  end

  // ==========================================================================
  // Read data registered: old value returned before the write lands
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      csr_rdata <= 32'h0000_0000;
    end else if (ce) begin
      csr_rdata <= cur_view;
    end
  end

  // ==========================================================================
  // Rounding mode resolution for the floating-point unit
  function automatic logic round_code_legal(input logic [2:0] code);
    case (code)
      FPCSR_RM_NEAREST_EVEN,
      FPCSR_RM_TOWARD_ZERO,
      FPCSR_RM_DOWNWARD,
      FPCSR_RM_UPWARD,
      FPCSR_RM_NEAREST_MAXMAG: round_code_legal = 1'b1;
      default:                 round_code_legal = 1'b0;
    endcase
  endfunction : round_code_legal

  always_comb begin
    if (instr_round_field == FPCSR_RM_DYNAMIC) begin
      fpu_round_mode    = round_sel;
      fpu_round_illegal = !round_code_legal(round_sel);
    end else begin
      fpu_round_mode    = instr_round_field;
      fpu_round_illegal = !round_code_legal(instr_round_field);
    end
  end

  // No trap or interrupt output exists: flags are status only
  assign dyn_round_mode   = round_sel;
  assign invalid_op_flag  = flags[FPCSR_FLAG_INVALID];
  assign div_by_zero_flag = flags[FPCSR_FLAG_DIVZERO];
  assign overflow_flag    = flags[FPCSR_FLAG_OVERFLOW];
  assign underflow_flag   = flags[FPCSR_FLAG_UNDERFL];
  assign inexact_flag     = flags[FPCSR_FLAG_INEXACT];

endmodule : fpcsr_bank

// ===== fpcsr_bank_monitor.sv
// Port checker for the floating-point CSR bank.
// Assumes one clock domain; bound to every bank instance below.
`timescale 1ns/1ps
module fpcsr_bank_monitor (
  input wire logic                 clk, rst, ce, csr_valid, csr_hit,
  input wire logic                 fpu_flags_valid, fpu_round_illegal, inexact_flag,
  input wire logic [11:0]          csr_addr,
  input wire fpcsr_pkg::fpcsr_op_t csr_op,
  input wire logic [31:0]          csr_wdata, csr_rdata,
  input wire logic [4:0]           fpu_flags,
  input wire logic [2:0]           instr_round_field, fpu_round_mode, dyn_round_mode
);
  import fpcsr_pkg::*;
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  sequence s_ctrl_swap;
    ce && csr_valid && csr_addr == FPCSR_ADDR_CTRL && csr_op == FPCSR_OP_WRITE;
  endsequence
  chk_hit_decode: assert property (csr_hit == (csr_valid && csr_addr inside {[1:3]}))
    else $error("address hit wrong");
  chk_ctrl_swap: assert property (s_ctrl_swap |=> csr_rdata[31:8] == 24'h0 &&
    csr_rdata[7:5] == $past(dyn_round_mode) && dyn_round_mode == $past(csr_wdata[7:5]))
    else $error("combined swap wrong");
  chk_round_view: assert property (ce && csr_valid && csr_addr == FPCSR_ADDR_ROUND
    |=> csr_rdata == {29'h0, $past(dyn_round_mode)}) else $error("rounding view wrong");
  chk_flags_view: assert property (ce && csr_valid && csr_addr == FPCSR_ADDR_FLAGS
    |=> csr_rdata[31:5] == 27'h0 && csr_rdata[0] == $past(inexact_flag)) else $error("flags view");
  chk_flag_set: assert property (ce && fpu_flags_valid && fpu_flags[0] |=> inexact_flag)
    else $error("flag not set");
  chk_static_mode: assert property (instr_round_field != 3'h7 |-> fpu_round_mode == instr_round_field)
    else $error("static mode wrong");
  chk_dyn_mode: assert property (instr_round_field == 3'h7 |-> fpu_round_mode == dyn_round_mode)
    else $error("dynamic mode wrong");
  chk_bad_code: assert property (fpu_round_illegal == (fpu_round_mode >= 3'h5))
    else $error("illegal code flag wrong");
endmodule : fpcsr_bank_monitor
bind fpcsr_bank fpcsr_bank_monitor u_mon (.*);

// ===== fpcsr_fpu_model.sv
// Floating-point unit stand-in that raises exception flags on request.
// Assumes the bench calls raise from one process only.
`timescale 1ns/1ps
module fpcsr_fpu_model (
  input  wire logic  clk,
  output logic       fpu_flags_valid = 1'h0,
  output logic [4:0] fpu_flags = 5'h1f
);
  // Idle flags are nonzero unless all five were last raised, so a bank that ignores the valid qualifier shows it
  task automatic raise(input logic [4:0] f);
    @(posedge clk) #1 {fpu_flags_valid, fpu_flags} = {1'h1, f};
    @(posedge clk) #1 {fpu_flags_valid, fpu_flags} = {1'h0, ~f};
  endtask : raise
endmodule : fpcsr_fpu_model

// ===== fpcsr_bank_tb.sv
// Self-checking bench for the floating-point CSR bank.
// Assumes the bound checker and the FPU model are compiled with it.
`timescale 1ns/1ps
module fpcsr_bank_tb;
  import fpcsr_pkg::*;
  logic        clk = 1'h0, rst = 1'h1, ce = 1'h1, csr_valid = 1'h0, csr_hit, ill, fv;
  logic [11:0] csr_addr = 12'h0;
  fpcsr_op_t   csr_op = FPCSR_OP_READ;
  logic [31:0] csr_wdata = 32'h0, csr_rdata;
  logic [4:0]  ff, fl;
  logic [2:0]  instr_round_field = 3'h0, rm, dynamic_round_select;
  int          failures = 0, n_checks = 0, cycles = 0;
  always #2.5 clk = ~clk;
  fpcsr_bank u_dut (.clk(clk), .rst(rst), .ce(ce), .csr_valid(csr_valid), .csr_addr(csr_addr),
    .csr_op(csr_op), .csr_wdata(csr_wdata), .csr_rdata(csr_rdata), .csr_hit(csr_hit),
    .fpu_flags_valid(fv), .fpu_flags(ff), .instr_round_field(instr_round_field),
    .fpu_round_mode(rm), .fpu_round_illegal(ill), .dyn_round_mode(dynamic_round_select), .invalid_op_flag(fl[4]),
    .div_by_zero_flag(fl[3]), .overflow_flag(fl[2]), .underflow_flag(fl[1]), .inexact_flag(fl[0]));
  fpcsr_fpu_model u_fpu (.clk(clk), .fpu_flags_valid(fv), .fpu_flags(ff));
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      failures++;
      $display("wrong value at %0t: %h not %h", $time, got, exp);
    end
  endtask : cmp
  // One access per call; the 1 ns delay after each edge keeps drivers off the sampling edge
  task automatic acc(input logic [11:0] a, input logic [31:0] e,
                     input fpcsr_op_t op = FPCSR_OP_READ, input logic [31:0] d = 32'h0);
    @(posedge clk) #1 {csr_valid, csr_addr, csr_wdata} = {1'h1, a, d};
    csr_op = op;
    @(posedge clk) #1 csr_valid = 1'h0;
    cmp(csr_rdata, e);
  endtask : acc
  task automatic t_views;
    acc(12'h3, 32'h0, FPCSR_OP_WRITE, 32'hffffffe5);
    acc(12'h3, 32'he5);
    acc(12'h2, 32'h7);
    acc(12'h1, 32'h5);
    acc(12'h4, 32'h0, FPCSR_OP_WRITE, 32'hff);
  endtask : t_views
  task automatic t_round;
    logic [2:0] e;
    for (int r = 0; r < 8; r++) begin
      acc(12'h2, 32'(r ? r - 1 : 7), FPCSR_OP_WRITE, 32'hfffffff8 | 32'(r));
      @(posedge clk) #1 instr_round_field = 3'h7;
      #1 cmp({28'h0, ill, rm}, {28'h0, r >= 5, 3'(r)});
      e = ((r ^ 1) == 7) ? 3'(r) : 3'(r ^ 1);
      @(posedge clk) #1 instr_round_field = 3'(r ^ 1);
      #1 cmp({28'h0, ill, rm}, {28'h0, e >= 3'h5, e});
    end
  endtask : t_round
  task automatic t_flags;
    u_fpu.raise(5'h11);
    #20 cmp({27'h0, fl}, 32'h15);
    acc(12'h1, 32'h15, FPCSR_OP_SET, 32'hffffff0a);
    acc(12'h1, 32'h1f, FPCSR_OP_CLEAR, 32'h3);
    acc(12'h1, 32'h1c, FPCSR_OP_WRITE, 32'hffffffe2);
    acc(12'h3, 32'he2);
  endtask : t_flags
  // Clock enable low must freeze storage and the read register
  task automatic t_freeze;
    @(posedge clk) #1 {ce, csr_valid, csr_addr, csr_wdata} = {1'h0, 1'h1, 12'h2, 32'h1};
    csr_op = FPCSR_OP_WRITE;
    @(posedge clk) #1 {ce, csr_valid} = 2'h2;
    cmp({29'h0, dynamic_round_select}, 32'h7);
    cmp(csr_rdata, 32'h0);
  endtask : t_freeze
  task automatic end_of_test;
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : end_of_test
  always @(posedge clk) begin
    if (++cycles == 2000) begin
      failures++;
      end_of_test();
    end
  end
  initial begin
    repeat (20) @(posedge clk);
    #1 rst = 1'h0;
    t_views();
    t_round();
    t_flags();
    t_freeze();
    end_of_test();
  end
endmodule : fpcsr_bank_tb
